/* File: src/ata_cmd_defs.vh */
`ifndef ATA_CMD_DEFS_VH
`define ATA_CMD_DEFS_VH
// Register byte offsets on the register bus
`define OFF_DATA 8'h00
`define OFF_FEAT 8'h04
`define OFF_SCNT 8'h08
`define OFF_SNUM 8'h0c
`define OFF_CYLL 8'h10
`define OFF_CYLH 8'h14
`define OFF_DRVH 8'h18
`define OFF_CMD 8'h1c
`define OFF_CFG 8'h20
// Opcodes
`define OP_READ 8'h20
`define OP_READ_NR 8'h21
`define OP_RLONG 8'h22
`define OP_RLONG_NR 8'h23
`define OP_INITP 8'h91
`define OP_SETMULT 8'hc6
`define OP_RDBUF 8'he4
`define OP_IDENT 8'hec
`define OP_SETFEAT 8'hef
// Feature codes
`define FEAT_NO_LOOKAHEAD 8'h55
`define FEAT_DEFAULTS 8'hcc
// Status and error bit positions
`define ST_BSY 7
`define ST_DRDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_ABRT 2
// Sector geometry, in 16-bit words
`define WORDS_SECTOR 9'd256
`define WORDS_ECC 9'd2
// Identify words
`define ID_W_GENCFG 8'd0
`define ID_W_CYL 8'd1
`define ID_W_HEADS 8'd3
`define ID_W_UBPT 8'd4
`define ID_W_UBPS 8'd5
`define ID_W_SPT 8'd6
`define ID_W_BUFTYPE 8'd20
`define ID_W_BUFSIZE 8'd21
`define ID_W_ECC 8'd22
`define ID_W_MULTMAX 8'd47
`define ID_W_DWORD 8'd48
`define ID_W_CAPS 8'd49
`define ID_W_PIO 8'd51
`define ID_W_DMATIM 8'd52
`define ID_W_CURCYL 8'd54
`define ID_W_CURHEADS 8'd55
`define ID_W_CURSPT 8'd56
`define ID_W_CAP_LO 8'd57
`define ID_W_CAP_HI 8'd58
`define ID_W_MULT 8'd59
`define ID_W_LBA_LO 8'd60
`define ID_W_LBA_HI 8'd61
`define ID_W_SWDMA 8'd62
`define ID_W_MWDMA 8'd63
`define ID_GENCFG 16'h848c
`define ID_UBPT 16'h4000
`define ID_UBPS 16'h0200
`define ID_BUFTYPE 16'h0003
`define ID_BUFSIZE 16'h0003
`define ID_ECC 16'h0004
`define ID_MULTMAX 16'h8008
`define ID_DWORD 16'h0000
`define ID_CAPS 16'h0201
`define ID_PIO 16'h0100
`define ID_DMATIM 16'h0100
`define ID_NODMA 16'h0000
`define ID_MULT_VALID 8
`endif

/* File: src/ident_words.v */
`timescale 1ns/100ps
`default_nettype none
`include "ata_cmd_defs.vh"
module ident_words #(
  parameter [15:0] CYLS = 16'h009c,
  parameter [15:0] HEADS = 16'h0002,
  parameter [15:0] SPT = 16'h0020
) (
  input wire [7:0] idx,
  input wire [7:0] mult,
  output reg [15:0] word
);
  wire [31:0] capacity;
  wire [31:0] last_lba;
  assign capacity = CYLS * HEADS * SPT;
  assign last_lba = capacity - 32'h00000001;
  always @*
  begin
    case (idx)
      `ID_W_GENCFG: word = `ID_GENCFG;
      `ID_W_CYL: word = CYLS;
      `ID_W_HEADS: word = HEADS;
      `ID_W_UBPT: word = `ID_UBPT;
      `ID_W_UBPS: word = `ID_UBPS;
      `ID_W_SPT: word = SPT;
      `ID_W_BUFTYPE: word = `ID_BUFTYPE;
      `ID_W_BUFSIZE: word = `ID_BUFSIZE;
      `ID_W_ECC: word = `ID_ECC;
      `ID_W_MULTMAX: word = `ID_MULTMAX;
      `ID_W_DWORD: word = `ID_DWORD;
      `ID_W_CAPS: word = `ID_CAPS;
      `ID_W_PIO: word = `ID_PIO;
      `ID_W_DMATIM: word = `ID_DMATIM;
      `ID_W_CURCYL: word = CYLS;
      `ID_W_CURHEADS: word = HEADS;
      `ID_W_CURSPT: word = SPT;
      `ID_W_CAP_LO: word = capacity[15:0];
      `ID_W_CAP_HI: word = capacity[31:16];
      `ID_W_MULT:
        word = {7'h00, (mult != 8'h00), mult};
      `ID_W_LBA_LO: word = last_lba[15:0];
      `ID_W_LBA_HI: word = last_lba[31:16];
      `ID_W_SWDMA: word = `ID_NODMA;
      `ID_W_MWDMA: word = `ID_NODMA;
      default: word = 16'h0000;
    endcase
  end
endmodule
`default_nettype wire

/* File: src/ata_cmd_core.v */
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ata_cmd_defs.vh"
module ata_cmd_core #(
  parameter [15:0] CYLS = 16'h009c,
  parameter [15:0] HEADS = 16'h0002,
  parameter [15:0] SPT = 16'h0020
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg intrq,
  output reg sec_req,
  output reg sec_long,
  output reg [7:0] sec_num,
  output reg [15:0] sec_cyl,
  output reg [3:0] sec_head,
  output reg lookahead_en,
  input wire fill_valid,
  input wire [15:0] fill_data,
  input wire fill_err,
  output wire fill_ready
);
  localparam S_IDLE = 2'd0;
  localparam S_IDENT = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam S_XFER = 2'd3;

  function mapped;
    input [7:0] a;
    begin
      mapped = (a == `OFF_DATA) || (a == `OFF_FEAT) || (a == `OFF_SCNT) ||
        (a == `OFF_SNUM) || (a == `OFF_CYLL) || (a == `OFF_CYLH) ||
        (a == `OFF_DRVH) || (a == `OFF_CMD) || (a == `OFF_CFG);
    end
  endfunction

  function is_data_in;
    input [7:0] op;
    begin
      is_data_in = (op == `OP_READ) || (op == `OP_READ_NR) ||
        (op == `OP_RLONG) || (op == `OP_RLONG_NR);
    end
  endfunction

  reg [15:0] buf_q [0:263];
  reg [1:0] state_q;
  reg [8:0] ptr_q;
  reg [8:0] len_q;
  reg [7:0] feat_q;
  reg [7:0] scnt_q;
  reg [7:0] snum_q;
  reg [7:0] cyll_q;
  reg [7:0] cylh_q;
  reg [7:0] drvh_q;
  reg [7:0] cmd_q;
  reg [7:0] err_q;
  reg bsy_q;
  reg drq_q;
  reg errst_q;
  reg [7:0] mult_q;
  reg [8:0] left_q;
  wire [15:0] id_word;
  wire [7:0] status;
  wire setup;
  wire done;
  wire wr;
  wire rd;

  ident_words #(
    .CYLS(CYLS),
    .HEADS(HEADS),
    .SPT(SPT)
  ) u_ident (
    .idx(ptr_q[7:0]),
    .mult(mult_q),
    .word(id_word)
  );

  assign status = {bsy_q, 1'b1, 1'b0, 1'b1, drq_q, 2'b00, errst_q};
  // Answer one cycle into the access phase so read data can be registered
  assign setup = psel && penable && !pready;
  assign done = psel && penable && pready;
  assign wr = done && pwrite;
  assign rd = done && !pwrite;
  assign fill_ready = (state_q == S_WAIT);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped(paddr);
      if (setup && !pwrite)
      begin
        case (paddr)
          `OFF_DATA: prdata <= {16'h0000, buf_q[ptr_q]};
          `OFF_FEAT: prdata <= {24'h000000, err_q};
          `OFF_SCNT: prdata <= {24'h000000, scnt_q};
          `OFF_SNUM: prdata <= {24'h000000, snum_q};
          `OFF_CYLL: prdata <= {24'h000000, cyll_q};
          `OFF_CYLH: prdata <= {24'h000000, cylh_q};
          `OFF_DRVH: prdata <= {24'h000000, drvh_q};
          `OFF_CMD: prdata <= {24'h000000, status};
          `OFF_CFG: prdata <= {23'h000000, lookahead_en, mult_q};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Buffer has no reset; a data-register read returns it whether or not data-request is set
  always @(posedge pclk)
  begin
    if (state_q == S_IDENT)
      buf_q[ptr_q] <= id_word;
    else if (state_q == S_WAIT && fill_valid)
      buf_q[ptr_q] <= fill_data;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_IDLE;
      ptr_q <= 9'd0;
      len_q <= `WORDS_SECTOR;
      feat_q <= 8'h00;
      scnt_q <= 8'h01;
      snum_q <= 8'h01;
      cyll_q <= 8'h00;
      cylh_q <= 8'h00;
      drvh_q <= 8'h00;
      cmd_q <= 8'h00;
      err_q <= 8'h00;
      bsy_q <= 1'b0;
      drq_q <= 1'b0;
      errst_q <= 1'b0;
      mult_q <= 8'h00;
      left_q <= 9'd0;
      intrq <= 1'b0;
      sec_req <= 1'b0;
      sec_long <= 1'b0;
      sec_num <= 8'h00;
      sec_cyl <= 16'h0000;
      sec_head <= 4'h0;
      lookahead_en <= 1'b1;
    end
    else
    begin
      // Set wins: a status read in the raising cycle does not drop intrq
      if (rd && paddr == `OFF_CMD)
        intrq <= 1'b0;
      // Parameter registers are only writable while idle and not busy
      if (wr && !bsy_q && !drq_q)
      begin
        case (paddr)
          `OFF_FEAT: feat_q <= pwdata[7:0];
          `OFF_SCNT: scnt_q <= pwdata[7:0];
          `OFF_SNUM: snum_q <= pwdata[7:0];
          `OFF_CYLL: cyll_q <= pwdata[7:0];
          `OFF_CYLH: cylh_q <= pwdata[7:0];
          `OFF_DRVH: drvh_q <= pwdata[7:0];
          default: ;
        endcase
      end
      case (state_q)
        S_IDLE:
        begin
          if (wr && paddr == `OFF_CMD && !bsy_q)
          begin
            cmd_q <= pwdata[7:0];
            err_q <= 8'h00;
            errst_q <= 1'b0;
            drq_q <= 1'b0;
            ptr_q <= 9'd0;
            bsy_q <= 1'b1;
            case (pwdata[7:0])
              `OP_IDENT:
              begin
                left_q <= 9'd1;
                len_q <= `WORDS_SECTOR;
                state_q <= S_IDENT;
              end
              `OP_RDBUF:
              begin
                left_q <= 9'd1;
                len_q <= `WORDS_SECTOR;
                state_q <= S_XFER;
                drq_q <= 1'b1;
                bsy_q <= 1'b0;
                intrq <= 1'b1;
              end
              `OP_SETFEAT:
              begin
                bsy_q <= 1'b0;
                intrq <= 1'b1;
                if (feat_q == `FEAT_NO_LOOKAHEAD)
                  lookahead_en <= 1'b0;
                else if (feat_q == `FEAT_DEFAULTS)
                begin
                  lookahead_en <= 1'b1;
                  mult_q <= 8'h00;
                end
                else
                begin
                  err_q[`ER_ABRT] <= 1'b1;
                  errst_q <= 1'b1;
                end
              end
              `OP_SETMULT:
              begin
                bsy_q <= 1'b0;
                intrq <= 1'b1;
                if (scnt_q == 8'h02 || scnt_q == 8'h04 || scnt_q == 8'h08 ||
                  scnt_q == 8'h10)
                  mult_q <= scnt_q;
                else
                begin
                  mult_q <= 8'h00;
                  err_q[`ER_ABRT] <= 1'b1;
                  errst_q <= 1'b1;
                end
              end
              `OP_INITP:
              begin
                // Identify geometry words are parameters and stay put
                bsy_q <= 1'b0;
                intrq <= 1'b1;
              end
              default:
              begin
                if (is_data_in(pwdata[7:0]))
                begin
                  left_q <= (scnt_q == 8'h00) ? 9'h100 : {1'b0, scnt_q};
                  sec_long <= (pwdata[7:0] == `OP_RLONG) ||
                    (pwdata[7:0] == `OP_RLONG_NR);
                  len_q <= ((pwdata[7:0] == `OP_RLONG) ||
                    (pwdata[7:0] == `OP_RLONG_NR)) ?
                    `WORDS_SECTOR + `WORDS_ECC : `WORDS_SECTOR;
                  sec_num <= snum_q;
                  sec_cyl <= {cylh_q, cyll_q};
                  sec_head <= drvh_q[3:0];
                  sec_req <= 1'b1;
                  state_q <= S_WAIT;
                end
                else
                begin
                  bsy_q <= 1'b0;
                  intrq <= 1'b1;
                  err_q[`ER_ABRT] <= 1'b1;
                  errst_q <= 1'b1;
                end
              end
            endcase
          end
        end
        S_IDENT:
        begin
          if (ptr_q == len_q - 9'd1)
          begin
            ptr_q <= 9'd0;
            drq_q <= 1'b1;
            bsy_q <= 1'b0;
            intrq <= 1'b1;
            state_q <= S_XFER;
          end
          else
            ptr_q <= ptr_q + 9'd1;
        end
        S_WAIT:
        begin
          sec_req <= 1'b0;
          if (fill_valid)
          begin
            if (fill_err)
            begin
              err_q[`ER_UNC] <= 1'b1;
              errst_q <= 1'b1;
            end
            if (ptr_q == len_q - 9'd1)
            begin
              ptr_q <= 9'd0;
              drq_q <= 1'b1;
              bsy_q <= 1'b0;
              intrq <= 1'b1;
              state_q <= S_XFER;
            end
            else
              ptr_q <= ptr_q + 9'd1;
          end
        end
        S_XFER:
        begin
          if (rd && paddr == `OFF_DATA)
          begin
            if (ptr_q == len_q - 9'd1)
            begin
              ptr_q <= 9'd0;
              drq_q <= 1'b0;
              left_q <= left_q - 9'd1;
              if (left_q == 9'd1)
                state_q <= S_IDLE;
              else
              begin
                bsy_q <= 1'b1;
                snum_q <= snum_q + 8'h01;
                sec_num <= snum_q + 8'h01;
                sec_req <= 1'b1;
                state_q <= S_WAIT;
              end
            end
            else
              ptr_q <= ptr_q + 9'd1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: sim/ata_cmd_core_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module ata_cmd_core_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic intrq,
  input wire logic sec_req,
  input wire logic sec_long,
  input wire logic [7:0] sec_num,
  input wire logic [15:0] sec_cyl,
  input wire logic [3:0] sec_head,
  input wire logic lookahead_en,
  input wire logic fill_valid,
  input wire logic [15:0] fill_data,
  input wire logic fill_err,
  input wire logic fill_ready
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_stat_rd;
    s_access ##0 pready && !pwrite && paddr == 8'h1c;
  endsequence
  a_one_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_error: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("unmapped address not refused");
  a_status_clears_irq: assert property (s_stat_rd |=> !intrq)
    else $error("interrupt stays after status read");
  a_request_pulse: assert property (sec_req |=> !sec_req)
    else $error("sector request longer than one cycle");
  a_reset_defaults: assert property ($rose(presetn) |-> lookahead_en && !intrq)
    else $error("wrong state after reset");
endmodule
bind ata_cmd_core ata_cmd_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .intrq(intrq), .sec_req(sec_req), .sec_long(sec_long),
  .sec_num(sec_num), .sec_cyl(sec_cyl), .sec_head(sec_head), .lookahead_en(lookahead_en),
  .fill_valid(fill_valid), .fill_data(fill_data), .fill_err(fill_err),
  .fill_ready(fill_ready));
`default_nettype wire

/* File: sim/sector_feeder.sv */
`timescale 1ns/100ps
`default_nettype none
module sector_feeder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sec_req,
  input wire logic fill_ready,
  input wire logic [15:0] base,
  input wire logic [8:0] err_at,
  output logic fill_valid,
  output logic [15:0] fill_data,
  output logic fill_err
);
  logic [15:0] n;
  logic [8:0] w;
  // Running word count keeps every value predictable to the bench
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fill_valid <= 1'b0;
      fill_data <= 16'h5a5a;
      fill_err <= 1'b0;
      n <= 16'h0;
      w <= 9'h0;
    end
    else if (fill_valid && fill_ready)
    begin
      fill_valid <= 1'b0;
      fill_err <= ~fill_err;
      n <= n + 16'h1;
      w <= w + 9'h1;
    end
    else if (sec_req)
      w <= 9'h0;
    else if (!fill_valid && fill_ready && $urandom_range(2) != 0)
    begin
      fill_valid <= 1'b1;
      fill_data <= base + n;
      fill_err <= (w == err_at);
    end
    // Idle word toggles so a stale capture cannot match
    if (!fill_valid || fill_ready)
      if (!(!fill_valid && fill_ready))
        fill_data <= ~fill_data;
  end
endmodule
`default_nettype wire

/* File: sim/ata_cmd_core_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ata_cmd_core_tb_top;
  localparam logic [15:0] CY = 16'h009c;
  localparam logic [15:0] HD = 16'h0002;
  localparam logic [15:0] ST = 16'h0020;
  localparam logic [31:0] CAP = {16'h0, CY} * {16'h0, HD} * {16'h0, ST};
  localparam logic [31:0] CAPM = CAP - 32'h1;
  localparam logic [7:0] FEATS [5] = '{8'h55, 8'h81, 8'h82, 8'haa, 8'hcc};
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, exp_long = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, intrq, sec_req, sec_long, lookahead_en, fill_valid, fill_err, fill_ready;
  logic [7:0] sec_num;
  logic [15:0] sec_cyl, fill_data;
  logic [15:0] base = 16'h0;
  logic [3:0] sec_head;
  logic [8:0] err_at = 9'h1ff;
  logic [7:0] exp_snum = 8'h05;
  logic [31:0] q[$];
  int n_errors = 0, comparisons = 0, cyc = 0, nfed = 0;
  always #12.5 pclk = ~pclk;
  ata_cmd_core #(.CYLS(CY), .HEADS(HD), .SPT(ST)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq), .sec_req(sec_req),
    .sec_long(sec_long), .sec_num(sec_num), .sec_cyl(sec_cyl), .sec_head(sec_head),
    .lookahead_en(lookahead_en), .fill_valid(fill_valid), .fill_data(fill_data),
    .fill_err(fill_err), .fill_ready(fill_ready));
  sector_feeder feeder (.pclk(pclk), .presetn(presetn), .sec_req(sec_req),
    .fill_ready(fill_ready), .base(base), .err_at(err_at), .fill_valid(fill_valid),
    .fill_data(fill_data), .fill_err(fill_err));
  task print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Mask in the upper half; a zero mask reads without comparing
  task apb(input logic w, input logic [7:0] a, input logic [31:0] mv);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0, mv[15:0]};
    if (!w)
      q.push_back({mv[31:16], mv[15:0] & mv[31:16]});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] mv);
    apb(1'b0, a, mv);
  endtask
  task wait_irq;
    while (intrq !== 1'b1)
      @(posedge pclk);
  endtask
  function logic [31:0] idw(input int i);
    case (i)
      1: return {16'hffff, CY};
      3: return {16'hffff, HD};
      6: return {16'hffff, ST};
      47: return 32'hffff_8008;
      48: return 32'hffff_0000;
      49: return 32'hffff_0201;
      51: return 32'hffff_0100;
      57: return {16'hffff, CAP[15:0]};
      58: return {16'hffff, CAP[31:16]};
      59: return 32'hffff_0108;
      60: return {16'hffff, CAPM[15:0]};
      61: return {16'hffff, CAPM[31:16]};
      62, 63: return 32'hffff_0000;
      default: return 32'h0;
    endcase
  endfunction
  task read_cmd(input logic [7:0] op, input int nsec, input int words, input logic [7:0] st);
    int k;
    int j;
    exp_long = op[1];
    wr(8'h08, nsec[15:0]);
    wr(8'h0c, 16'h0005);
    wr(8'h10, 16'h0023);
    wr(8'h14, 16'h0001);
    wr(8'h18, 16'h00a1);
    exp_snum = 8'h05;
    wr(8'h1c, {8'h0, op});
    rd(8'h1c, 32'h0080_0080);
    for (k = 0; k < nsec; k++)
    begin
      wait_irq();
      rd(8'h1c, {16'h00ff, 8'h0, st});
      for (j = 0; j < words; j++)
      begin
        rd(8'h00, {16'hffff, base + nfed[15:0]});
        nfed++;
      end
    end
    rd(8'h1c, 32'h0088_0000);
  endtask
  always @(posedge pclk)
  begin
    logic [31:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      e = q.pop_front();
      if (e[31:16] != 16'h0)
        chk(prdata[15:0] & e[31:16], e[15:0]);
    end
    if (sec_req === 1'b1)
    begin
      chk(sec_cyl, 16'h0123);
      chk({12'h0, sec_head}, 16'h0001);
      chk({15'h0, sec_long}, {15'h0, exp_long});
      chk({8'h0, sec_num}, {8'h0, exp_snum});
      exp_snum <= exp_snum + 8'h01;
    end
  end
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  initial
  begin
    int i;
    void'($urandom(32'ha1da));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h20, 32'h0100_0100);
    rd(8'h40, 32'h0);
    for (i = 0; i < 5; i++)
    begin
      wr(8'h04, {8'h0, FEATS[i]});
      wr(8'h1c, 16'h00ef);
      wait_irq();
      rd(8'h1c, (i == 0 || i == 4) ? 32'h00ff_0050 : 32'h00ff_0051);
      rd(8'h04, (i == 0 || i == 4) ? 32'h0004_0000 : 32'h0004_0004);
      rd(8'h20, (i == 4) ? 32'h0100_0100 : 32'h0100_0000);
    end
    wr(8'h08, 16'h0008);
    wr(8'h1c, 16'h00c6);
    wait_irq();
    rd(8'h1c, 32'h00ff_0050);
    wr(8'h1c, 16'h0091);
    wait_irq();
    rd(8'h1c, 32'h00ff_0050);
    wr(8'h1c, 16'h00ec);
    rd(8'h1c, 32'h0080_0080);
    wait_irq();
    rd(8'h1c, 32'h00ff_0058);
    for (i = 0; i < 256; i++)
      rd(8'h00, idw(i));
    rd(8'h1c, 32'h0088_0000);
    base <= 16'($urandom);
    read_cmd(8'h20, 1 + $urandom % 3, 256, 8'h58);
    err_at <= 9'd5;
    read_cmd(8'h22, 1, 258, 8'h59);
    rd(8'h04, 32'h0040_0040);
    print_verdict();
  end
endmodule
`default_nettype wire
